// ===== design/osccr_pkg.sv
`default_nettype none
package osccr_pkg;
    // ***************************************************
    // Register map
    // ***************************************************
    localparam logic [7:0] HF_CTRL_ADDR = 8'hb2;
    localparam logic [7:0] CLOCK_MULT_COMPAT_ADDR = 8'hb9;
    localparam logic [7:0] LF_CTRL_ADDR = 8'h86;
    localparam logic [7:0] HF_CTRL_RESET = 8'hc0;
    localparam logic [7:0] CLOCK_MULT_COMPAT_VALUE = 8'he0;
    localparam logic [1:0] HF_DIV_RESET = 2'h0;
    localparam logic [1:0] LF_DIV_RESET = 2'h0;
    localparam logic [3:0] LF_TUNE_RESET = 4'h8;
    // ***************************************************
    // Field positions
    // ***************************************************
    localparam int EN_BIT = 7;
    localparam int RDY_BIT = 6;
    localparam int SUSP_BIT = 5;
    localparam int TUNE_LSB = 2;
    localparam int TUNE_MSB = 5;
    localparam int DIV_LSB = 0;
    localparam int DIV_MSB = 1;
    // ***************************************************
    // Timing
    // ***************************************************
    localparam int CLK_MHZ = 50;
    localparam int CLK_HZ = 50_000_000;
    localparam int HF_PRE_DIV = 4;
    localparam int HF_SETTLE_NS = 1000;
    localparam int HF_SETTLE_CYC = (HF_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int LF_NOMINAL_HZ = 80_000;
    localparam int LF_HALF_CYC = CLK_HZ / (2 * LF_NOMINAL_HZ);
    localparam int LF_TUNE_STEP_CYC = 4;
    localparam int LF_SETTLE_NS = 20000;
    localparam int LF_SETTLE_CYC = (LF_SETTLE_NS * CLK_MHZ + 999) / 1000;
    // ***************************************************
    // H-F oscillator states
    // ***************************************************
    typedef enum logic [3:0] {
        HF_OFF = 4'b0001,
        HF_SETTLE = 4'b0010,
        HF_READY = 4'b0100,
        HF_SUSPEND = 4'b1000
    } osccr_hf_state_t;
endpackage : osccr_pkg
`default_nettype wire

// ===== design/osccr_top.sv
// Function
// - Control bit 7 enables the H-F oscillator; resets to one.
// - Read-only bit 6 reads one only while running at programmed rate.
// - Writing one to bit 5 suspends the oscillator and stops its clock.
// - Suspended oscillator restarts on a wake event without software help.
// - Bits 4:2 of the H-F control register read zero; writes ignored.
// - H-F clock divided by four, then by the post-divider field.
// - Post-divider 00 by 8, 01 by 4, 10 by 2, 11 by 1.
// - Multiplier register acts as if a multiplier existed.
// - Multiplier enable bit 7 always reads one.
// - Multiplier initialize bit 6 accepts writes, no effect, reads one.
// - Multiplier ready bit 5 always reads one.
// - Multiplier input select bits 1:0 always read 00.
// - L-F oscillator nominal rate is 80 kHz.
// - L-F output divider selectable by 1, 2, 4 or 8.
// - Four-bit fine-tune field adjusts L-F output frequency.
// - Capture mode: timer 2 on falling, timer 3 on rising L-F edge.
// - On capture, timer count bytes copy into reload bytes.
// - Wake resumes oscillator and processor whether or not interrupt fires.
// - L-F divider field: 00 by 8, 01 by 4, 10 by 2, 11 by 1.
// - L-F ready clears only on reset or L-F divider change.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module osccr_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic wake_port0_match,
    input wire logic wake_port1_match,
    input wire logic wake_timer3_overflow,
    input wire logic wake_usb_resume,
    input wire logic t2_lf_capture_mode,
    input wire logic t3_lf_capture_mode,
    input wire logic [15:0] t2_count,
    input wire logic [15:0] t3_count,
    output logic hf_osc_enable,
    output logic hf_osc_suspended,
    output logic cpu_resume,
    output logic system_clock_en,
    output logic lf_osc_enable,
    output logic lf_clock_out,
    output logic t2_capture,
    output logic [15:0] t2_reload_bytes,
    output logic t3_capture,
    output logic [15:0] t3_reload_bytes
);
    // ***************************************************
    // Divider decode, shared by both oscillators
    // ***************************************************
    function automatic logic [3:0] div_ratio(input logic [1:0] sel);
        case (sel)
            2'h0: div_ratio = 4'h8;
            2'h1: div_ratio = 4'h4;
            2'h2: div_ratio = 4'h2;
            default: div_ratio = 4'h1;
        endcase
    endfunction : div_ratio

    // ***************************************************
    // Register decode
    // ***************************************************
    logic [1:0] hf_post_divider;
    logic [1:0] lf_divider_select;
    logic [3:0] lf_fine_tune;
    logic lf_ready_flag;
    logic [6:0] hf_settle_cnt;
    logic [9:0] lf_settle_cnt;
    logic [1:0] hf_pre_cnt;
    logic [2:0] hf_post_cnt;
    logic [9:0] lf_half_cnt;
    logic [2:0] lf_div_cnt;
    logic lf_prev;
    osccr_pkg::osccr_hf_state_t hf_state;
    osccr_pkg::osccr_hf_state_t hf_state_next;

    wire hf_wr = reg_wr && (reg_addr == osccr_pkg::HF_CTRL_ADDR);
    wire lf_wr = reg_wr && (reg_addr == osccr_pkg::LF_CTRL_ADDR);
    wire suspend_req = hf_wr && reg_wdata[osccr_pkg::SUSP_BIT];
    wire wake_any = wake_port0_match || wake_port1_match
        || wake_timer3_overflow || wake_usb_resume;
    wire hf_freq_ready = (hf_state == osccr_pkg::HF_READY);
    wire hf_running = (hf_state == osccr_pkg::HF_READY)
        || (hf_state == osccr_pkg::HF_SETTLE);
    wire lf_div_change = lf_wr
        && (reg_wdata[osccr_pkg::DIV_MSB:osccr_pkg::DIV_LSB]
            != lf_divider_select);
    wire [7:0] hf_ctrl_rd = {hf_osc_enable, hf_freq_ready, hf_osc_suspended,
        3'h0, hf_post_divider};
    wire [7:0] lf_ctrl_rd = {lf_osc_enable, lf_ready_flag, lf_fine_tune,
        lf_divider_select};
    // Multiplier absent; constant image keeps legacy code happy
    wire [7:0] clock_mult_compat_rd = osccr_pkg::CLOCK_MULT_COMPAT_VALUE;
    wire [7:0] rdata_next =
        (reg_addr == osccr_pkg::HF_CTRL_ADDR) ? hf_ctrl_rd :
        (reg_addr == osccr_pkg::CLOCK_MULT_COMPAT_ADDR) ? clock_mult_compat_rd :
        (reg_addr == osccr_pkg::LF_CTRL_ADDR) ? lf_ctrl_rd : 8'h00;

    always_ff @(posedge clk)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= reg_rd ? rdata_next : 8'h00;
    end

    // ***************************************************
    // H-F control register
    // ***************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hf_osc_enable <= osccr_pkg::HF_CTRL_RESET[osccr_pkg::EN_BIT];
            hf_post_divider <= osccr_pkg::HF_DIV_RESET;
        end
        else if (hf_wr)
        begin
            hf_osc_enable <= reg_wdata[osccr_pkg::EN_BIT];
            hf_post_divider <=
                reg_wdata[osccr_pkg::DIV_MSB:osccr_pkg::DIV_LSB];
        end
    end

    // ***************************************************
    // H-F oscillator state
    // ***************************************************
    wire hf_settle_done = (hf_settle_cnt
        == 7'(osccr_pkg::HF_SETTLE_CYC - 1));

    always_comb
    begin
        hf_state_next = hf_state;
        case (hf_state)
            osccr_pkg::HF_OFF:
                if (hf_osc_enable)
                    hf_state_next = osccr_pkg::HF_SETTLE;
            osccr_pkg::HF_SETTLE:
                if (!hf_osc_enable)
                    hf_state_next = osccr_pkg::HF_OFF;
                else if (hf_osc_suspended)
                    hf_state_next = osccr_pkg::HF_SUSPEND;
                else if (hf_settle_done)
                    hf_state_next = osccr_pkg::HF_READY;
            osccr_pkg::HF_READY:
                if (!hf_osc_enable)
                    hf_state_next = osccr_pkg::HF_OFF;
                else if (hf_osc_suspended)
                    hf_state_next = osccr_pkg::HF_SUSPEND;
            osccr_pkg::HF_SUSPEND:
                if (!hf_osc_suspended)
                    hf_state_next = osccr_pkg::HF_SETTLE;
            default:
                hf_state_next = osccr_pkg::HF_OFF;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            hf_state <= osccr_pkg::HF_READY;
        else
            hf_state <= hf_state_next;
    end

    always_ff @(posedge clk)
    begin
        if (rst || hf_state != osccr_pkg::HF_SETTLE)
            hf_settle_cnt <= 7'h00;
        else if (!hf_settle_done)
            hf_settle_cnt <= hf_settle_cnt + 7'h01;
    end

    // Software set beats a coincident wake so a suspend is never dropped
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hf_osc_suspended <= 1'b0;
            cpu_resume <= 1'b0;
        end
        else
        begin
            cpu_resume <= 1'b0;
            if (suspend_req)
                hf_osc_suspended <= 1'b1;
            else if (hf_osc_suspended && wake_any)
            begin
                hf_osc_suspended <= 1'b0;
                cpu_resume <= 1'b1;
            end
        end
    end

    // ***************************************************
    // System clock enable: divide by four, then post-divide
    // ***************************************************
    wire [3:0] hf_ratio = div_ratio(hf_post_divider);
    wire pre_tick = (hf_pre_cnt == 2'(osccr_pkg::HF_PRE_DIV - 1));
    wire post_last = (hf_post_cnt == 3'(hf_ratio - 4'h1));

    // Restart on any H-F control write so a new ratio starts on a clean edge
    always_ff @(posedge clk)
    begin
        if (rst || !hf_running || hf_wr)
        begin
            hf_pre_cnt <= 2'h0;
            hf_post_cnt <= 3'h0;
            system_clock_en <= 1'b0;
        end
        else
        begin
            hf_pre_cnt <= hf_pre_cnt + 2'h1;
            system_clock_en <= pre_tick && post_last;
            if (pre_tick)
                hf_post_cnt <= post_last ? 3'h0 : hf_post_cnt + 3'h1;
        end
    end

    // ***************************************************
    // L-F control register
    // ***************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lf_osc_enable <= 1'b0;
            lf_fine_tune <= osccr_pkg::LF_TUNE_RESET;
            lf_divider_select <= osccr_pkg::LF_DIV_RESET;
        end
        else if (lf_wr)
        begin
            lf_osc_enable <= reg_wdata[osccr_pkg::EN_BIT];
            lf_fine_tune <=
                reg_wdata[osccr_pkg::TUNE_MSB:osccr_pkg::TUNE_LSB];
            lf_divider_select <=
                reg_wdata[osccr_pkg::DIV_MSB:osccr_pkg::DIV_LSB];
        end
    end

    // Disabling does not drop ready; only a divider change does
    always_ff @(posedge clk)
    begin
        if (rst || lf_div_change)
        begin
            lf_ready_flag <= 1'b0;
            lf_settle_cnt <= 10'h000;
        end
        else if (lf_osc_enable && !lf_ready_flag)
        begin
            if (lf_settle_cnt == 10'(osccr_pkg::LF_SETTLE_CYC - 1))
                lf_ready_flag <= 1'b1;
            else
                lf_settle_cnt <= lf_settle_cnt + 10'h001;
        end
    end

    // ***************************************************
    // L-F oscillator: half period stretched by fine-tune
    // ***************************************************
    wire [9:0] lf_half_lim = 10'(osccr_pkg::LF_HALF_CYC - 1)
        + 10'({lf_fine_tune, 2'b00});
    wire lf_half_tick = (lf_half_cnt == lf_half_lim);
    wire [3:0] lf_ratio = div_ratio(lf_divider_select);
    wire lf_div_last = (lf_div_cnt == 3'(lf_ratio - 4'h1));

    always_ff @(posedge clk)
    begin
        if (rst || !lf_osc_enable)
        begin
            lf_half_cnt <= 10'h000;
            lf_div_cnt <= 3'h0;
            lf_clock_out <= 1'b0;
        end
        else if (lf_half_tick)
        begin
            lf_half_cnt <= 10'h000;
            lf_div_cnt <= lf_div_last ? 3'h0 : lf_div_cnt + 3'h1;
            if (lf_div_last)
                lf_clock_out <= !lf_clock_out;
        end
        else
            lf_half_cnt <= lf_half_cnt + 10'h001;
    end

    // ***************************************************
    // Timer capture of L-F edges
    // ***************************************************
    wire lf_fall = lf_prev && !lf_clock_out;
    wire lf_rise = !lf_prev && lf_clock_out;
    wire t2_cap_hit = t2_lf_capture_mode && lf_fall;
    wire t3_cap_hit = t3_lf_capture_mode && lf_rise;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lf_prev <= 1'b0;
            t2_capture <= 1'b0;
            t3_capture <= 1'b0;
            t2_reload_bytes <= 16'h0000;
            t3_reload_bytes <= 16'h0000;
        end
        else
        begin
            lf_prev <= lf_clock_out;
            t2_capture <= t2_cap_hit;
            t3_capture <= t3_cap_hit;
            if (t2_cap_hit)
                t2_reload_bytes <= t2_count;
            if (t3_cap_hit)
                t3_reload_bytes <= t3_count;
        end
    end

    // ***************************************************
    // Checks
    // ***************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic [5:0] gap_cnt;
    logic gap_valid;
    always_ff @(posedge clk)
    begin
        if (rst || !hf_running || hf_wr)
        begin
            gap_cnt <= 6'h00;
            gap_valid <= 1'b0;
        end
        else if (system_clock_en)
        begin
            gap_cnt <= 6'h00;
            gap_valid <= 1'b1;
        end
        else
            gap_cnt <= gap_cnt + 6'h01;
    end

    sequence s_suspend_write;
        hf_wr && reg_wdata[osccr_pkg::SUSP_BIT];
    endsequence
    sequence s_wake_seen;
        hf_osc_suspended && wake_any && !suspend_req;
    endsequence

    a_hf_enable_write: assert property (
        hf_wr |=> hf_osc_enable == $past(reg_wdata[osccr_pkg::EN_BIT]))
        else $error("enable bit did not follow write");
    a_hf_ready_off: assert property (
        (!hf_osc_enable || hf_osc_suspended) |=> !hf_freq_ready)
        else $error("ready set while off or suspended");
    a_hf_ready_settle: assert property (
        $rose(hf_state == osccr_pkg::HF_SETTLE) |->
        !hf_freq_ready [*8])
        else $error("ready before settling");
    a_suspend_enter: assert property (
        s_suspend_write |=> hf_osc_suspended ##1 !system_clock_en [*4])
        else $error("suspend did not stop clock");
    a_wake_resume: assert property (
        s_wake_seen |=> !hf_osc_suspended && cpu_resume
        ##[1:80] system_clock_en || !hf_osc_enable || hf_osc_suspended)
        else $error("wake did not resume clock");
    a_unused_zero: assert property (
        reg_rd && reg_addr != osccr_pkg::LF_CTRL_ADDR
        |=> reg_rdata[4:2] == 3'h0)
        else $error("unused bits not zero");
    a_clock_mult_compat_fixed: assert property (
        reg_rd && reg_addr == osccr_pkg::CLOCK_MULT_COMPAT_ADDR
        |=> reg_rdata == 8'he0)
        else $error("multiplier register image wrong");
    a_post_div_gap: assert property (
        system_clock_en && gap_valid |->
        gap_cnt == 6'(osccr_pkg::HF_PRE_DIV * div_ratio(hf_post_divider) - 1))
        else $error("system clock period wrong");
    a_lf_ready_hold: assert property (
        lf_ready_flag && !lf_div_change |=> lf_ready_flag)
        else $error("lf ready dropped without cause");
    a_t2_capture: assert property (
        t2_cap_hit |=> t2_capture && t2_reload_bytes == $past(t2_count))
        else $error("timer 2 capture missed");
    a_t3_capture: assert property (
        t3_lf_capture_mode && $rose(lf_clock_out)
        |=> t3_capture && t3_reload_bytes == $past(t3_count))
        else $error("timer 3 capture missed");
endmodule : osccr_top
`default_nettype wire

// ===== verification/osccr_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module osccr_top_tb;
    // ***************************************************
    // Signals
    // ***************************************************
    logic clk, rst, reg_wr, reg_rd, t2_mode, t3_mode, cap_on, lf_prev, rd_seen;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] wake;
    logic [15:0] t2_count, t3_count, t2_rl, t3_rl, t3_prev_rl;
    logic hf_en, hf_susp, resume, sc_en, lf_en, lf_out, t2_cap, t3_cap;
    logic [7:0] rd_q[$];
    logic [15:0] t2_q[$], t3_q[$];
    int error_cnt, total_checks, cyc, sc_cnt, sc_last, sc_num, lf_cnt, lf_last;
    int cap_cnt, snap, half, t3_per;
    integer seed = 32'h4d4977e7;
    logic [3:0] tn [5] = '{4'h0, 4'hf, 4'h4, 4'h1, 4'h0};
    logic [1:0] dv [5] = '{2'h3, 2'h3, 2'h2, 2'h1, 2'h0};
    logic [1:0] prev_div;

    osccr_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .wake_port0_match(wake[0]),
        .wake_port1_match(wake[1]), .wake_timer3_overflow(wake[2]),
        .wake_usb_resume(wake[3]), .t2_lf_capture_mode(t2_mode),
        .t3_lf_capture_mode(t3_mode), .t2_count(t2_count),
        .t3_count(t3_count), .hf_osc_enable(hf_en),
        .hf_osc_suspended(hf_susp), .cpu_resume(resume),
        .system_clock_en(sc_en), .lf_osc_enable(lf_en),
        .lf_clock_out(lf_out), .t2_capture(t2_cap),
        .t2_reload_bytes(t2_rl), .t3_capture(t3_cap),
        .t3_reload_bytes(t3_rl));

    // ***************************************************
    // Reporting
    // ***************************************************
    task automatic fail(input string m);
    begin
        error_cnt++;
        $display("unexpected at %0t: %s", $time, m);
    end
    endtask : fail

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    begin
        total_checks++;
        if (got !== exp)
            fail($sformatf("read %h want %h", got, exp));
    end
    endtask : chk_reg

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    begin
        total_checks++;
        if (got !== exp)
            fail($sformatf("value %0d want %0d", got, exp));
    end
    endtask : chk_val

    task automatic final_report();
    begin
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask : final_report

    // ***************************************************
    // Bus master
    // ***************************************************
    task automatic tick(input int n);
    begin
        repeat (n) @(posedge clk);
    end
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
    begin
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    begin
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rd_q.push_back(exp);
        @(posedge clk);
        reg_rd <= 1'b0;
    end
    endtask : rd

    // ***************************************************
    // Clock, timeout and monitor
    // ***************************************************
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            fail("timeout");
            final_report();
        end
    end

    // Capture stimulus only in its own phase, so seed use never races
    // Timer 3 counts cycles so capture differences give the period
    always @(posedge clk)
    begin
        if (cap_on)
        begin
            t2_count <= $random(seed);
            t3_count <= t3_count + 16'h1;
            t2_mode <= $random(seed);
            t3_mode <= 1'b1;
        end
    end

    always @(posedge clk)
    begin
        if (rd_seen)
            chk_reg(reg_rdata, rd_q.pop_front());
        else if (!rst && reg_rdata !== 8'h00)
            fail("read data outside its cycle");
        rd_seen <= reg_rd;
        if (t2_cap)
        begin
            cap_cnt++;
            if (t2_q.size() == 0)
                fail("timer 2 capture without falling edge");
            else
                chk_val(t2_rl, t2_q.pop_front());
        end
        if (t3_cap)
        begin
            cap_cnt++;
            t3_per <= 16'(t3_rl - t3_prev_rl);
            t3_prev_rl <= t3_rl;
            if (t3_q.size() == 0)
                fail("timer 3 capture without rising edge");
            else
                chk_val(t3_rl, t3_q.pop_front());
        end
        if (t2_mode && lf_prev && !lf_out)
            t2_q.push_back(t2_count);
        if (t3_mode && !lf_prev && lf_out)
            t3_q.push_back(t3_count);
        lf_prev <= lf_out;
        sc_cnt <= sc_en ? 0 : sc_cnt + 1;
        if (sc_en)
        begin
            sc_last <= sc_cnt + 1;
            sc_num <= sc_num + 1;
        end
        lf_cnt <= (lf_out != lf_prev) ? 0 : lf_cnt + 1;
        if (lf_out != lf_prev)
            lf_last <= lf_cnt + 1;
    end

    // ***************************************************
    // Scenarios
    // ***************************************************
    initial
    begin
        {rst, reg_wr, reg_rd, t2_mode, t3_mode, cap_on} = 6'h20;
        {lf_prev, rd_seen, reg_addr, reg_wdata, wake} = '0;
        {t2_count, t3_count} = '0;
        tick(2);
        rst <= 1'b0;
        rd(8'hb2, 8'hc0);
        rd(8'hb9, 8'he0);
        rd(8'h86, 8'h20);
        rd(8'h44, 8'h00);
        wr(8'hb9, 8'h40);
        for (int i = 0; i < 3; i++)
        begin
            rd(8'hb9, 8'he0);
            wr(8'hb9, $random(seed));
        end
        // Post-divider ratios, junk in the unused bits
        for (int d = 0; d < 4; d++)
        begin
            wr(8'hb2, {3'b100, 3'($random(seed)), 2'(d)});
            rd(8'hb2, {6'h30, 2'(d)});
            tick(104);
            chk_val(sc_last, 32'd4 << (3 - d));
        end
        wr(8'hb2, 8'h03);
        tick(1);
        chk_val(hf_en, 0);
        rd(8'hb2, 8'h03);
        snap = sc_num;
        tick(64);
        chk_val(sc_num - snap, 0);
        wr(8'hb2, 8'h83);
        tick(60);
        chk_val(hf_en, 1);
        rd(8'hb2, 8'hc3);
        // Each wake source ends a suspend
        for (int k = 0; k < 4; k++)
        begin
            wr(8'hb2, 8'ha3);
            tick(1);
            chk_val(hf_susp, 1);
            rd(8'hb2, 8'ha3);
            snap = sc_num;
            tick(40);
            chk_val(sc_num - snap, 0);
            wake <= 4'h1 << k;
            tick(1);
            wake <= 4'h0;
            tick(1);
            chk_val({resume, hf_susp}, 2);
            tick(60);
            rd(8'hb2, 8'hc3);
        end
        // Wake without suspend must be ignored
        wake <= 4'hf;
        tick(1);
        wake <= 4'h0;
        tick(1);
        chk_val({resume, hf_susp}, 0);
        // L-F rates with capture traffic running
        cap_on <= 1'b1;
        prev_div = 2'h0;
        for (int i = 0; i < 5; i++)
        begin
            wr(8'h86, {2'b10, tn[i], dv[i]});
            rd(8'h86, {1'b1, i > 0 && dv[i] == prev_div, tn[i], dv[i]});
            prev_div = dv[i];
            half = osccr_pkg::LF_HALF_CYC + osccr_pkg::LF_TUNE_STEP_CYC * tn[i];
            half = half << (3 - dv[i]);
            tick(1100 + 5 * half);
            chk_val(lf_last, half);
            chk_val(t3_per, 2 * half);
            rd(8'h86, {2'b11, tn[i], dv[i]});
        end
        chk_val(lf_en, 1);
        cap_on <= 1'b0;
        tick(1);
        t2_mode <= 1'b0;
        t3_mode <= 1'b0;
        tick(4);
        chk_val(cap_cnt > 0, 1);
        chk_val(t2_q.size() + t3_q.size(), 0);
        final_report();
    end
endmodule : osccr_top_tb
`default_nettype wire
